// *** torque_cutoff_pkg.sv ***
// Constants and carrier types for the dual-channel torque cutoff monitor
package torque_cutoff_pkg;
  localparam int unsigned CLK_FREQ_HZ       = 100_000_000;        // System clock rate
  localparam int unsigned CLK_PERIOD_NS     = 10;                 // Clock period
  localparam int unsigned FILTER_TIME_MS    = 6;                  // Low-going filter, typical
  localparam int unsigned DISC_TIME_MS      = 2300;               // Discrepancy time, typical
  localparam int unsigned FILTER_CYCLES     = FILTER_TIME_MS * (CLK_FREQ_HZ / 1000);
  localparam int unsigned DISC_CYCLES       = DISC_TIME_MS * (CLK_FREQ_HZ / 1000);
  localparam int unsigned CNT_W             = 32;                 // Counter width
  localparam logic [1:0]  SYNC_RESET        = 2'h0;               // Synchroniser reset value

  // Channel pair carried together
  typedef struct packed {
    logic chan_a;
    logic chan_b;
  } permit_pair_type;

  // Supervision states
  typedef enum logic [1:0] {
    ST_SAFE,
    ST_RUN,
    ST_DISAGREE,
    ST_LOCKED
  } monitor_state_type;
endpackage : torque_cutoff_pkg

// *** safe_torque_cutoff.sv ***
// Dual-channel torque cutoff supervision with discrepancy latch
//
// Contract
// - Both low: block, trip, status on
// - Both high: run allowed, status off
// - Channels differ: block, trip, status off
// - Short discrepancy never raises fault
// - Torque stops within response window
// - Unpowered: no run, status off
// - Aux supply alone keeps status live
// - Supervision can never be disabled
// - Short low test pulses are ignored
`timescale 1ns/1ps
module safe_torque_cutoff
  import torque_cutoff_pkg::*;
#(
  parameter int unsigned FILTER_LEN = FILTER_CYCLES,  // Low filter length in cycles
  parameter int unsigned DISC_LEN   = DISC_CYCLES     // Discrepancy limit in cycles
) (
  // Clock and power-on reset
  input  wire logic            clk,
  input  wire logic            resetn,
  // Supply presence
  input  wire logic            logic_powered,      // Auxiliary or mains logic supply up
  input  wire logic            mains_powered,      // Power stage supply up
  // Permit channels
  input  wire permit_pair_type permit_in,
  input  wire logic            software_run,       // Run request from drive software
  // Results
  output logic                 torque_enable,      // Motor power allowed
  output logic                 start_allowed,      // Drive may start
  output logic                 cutoff_trip,        // Torque cutoff trip report
  output logic                 fault_latched,      // Discrepancy fault locked
  output logic                 safe_state_output_a,
  output logic                 safe_state_output_b
);

  // Two-stage synchronisers; first stage read only by second
  logic [1:0] sync1_reg;
  logic [1:0] sync2_reg;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync1_reg <= SYNC_RESET;
      sync2_reg <= SYNC_RESET;
    end else begin
      sync1_reg <= {permit_in.chan_a, permit_in.chan_b};
      sync2_reg <= sync1_reg;
    end
  end

  // Low-going filter per channel: rising is immediate, falling after FILTER_LEN
  // cycles. This trades a few ms of response for immunity to test pulses.
  logic [CNT_W-1:0] low_cnt_reg [2];
  logic [1:0]       filt_reg;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      low_cnt_reg[0] <= '0;
      low_cnt_reg[1] <= '0;
      filt_reg       <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (sync2_reg[i]) begin
          low_cnt_reg[i] <= '0;
          filt_reg[i]    <= 1'b1;
        end else if (low_cnt_reg[i] >= CNT_W'(FILTER_LEN - 1)) begin
          filt_reg[i]    <= 1'b0;
        end else begin
          low_cnt_reg[i] <= low_cnt_reg[i] + 1'b1;
        end
      end
    end
  end

  // Decoded channel combinations
  wire both_high = filt_reg[1] & filt_reg[0];
  wire both_low  = ~filt_reg[1] & ~filt_reg[0];
  wire disagree  = filt_reg[1] ^ filt_reg[0];

  // Discrepancy timer, cleared whenever the channels agree
  logic [CNT_W-1:0]  disc_cnt_reg;
  monitor_state_type state_reg;
  monitor_state_type state_next;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      disc_cnt_reg <= '0;
    end else if (!disagree || state_reg == ST_LOCKED) begin
      disc_cnt_reg <= '0;
    end else begin
      disc_cnt_reg <= disc_cnt_reg + 1'b1;
    end
  end
  wire disc_expired = disc_cnt_reg >= CNT_W'(DISC_LEN - 1);

  // Next state; locked state has no exit but reset, which is power-on only
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_LOCKED:   state_next = ST_LOCKED;
      ST_DISAGREE: begin
        if (disc_expired)   state_next = ST_LOCKED;
        else if (both_low)  state_next = ST_SAFE;
        else if (both_high) state_next = ST_RUN;
      end
      default: begin
        if (disagree)       state_next = ST_DISAGREE;
        else if (both_high) state_next = ST_RUN;
        else                state_next = ST_SAFE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) state_reg <= ST_SAFE;
    else         state_reg <= state_next;
  end

  // Output decode; no input disables supervision
  wire run_ok    = (state_next == ST_RUN) && logic_powered && mains_powered;
  wire status_on = (state_next == ST_SAFE) && logic_powered;

  // Registered outputs
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      torque_enable       <= 1'b0;
      start_allowed       <= 1'b0;
      cutoff_trip         <= 1'b1;
      fault_latched       <= 1'b0;
      safe_state_output_a <= 1'b0;
      safe_state_output_b <= 1'b0;
    end else begin
      torque_enable       <= run_ok && software_run;
      start_allowed       <= run_ok;
      cutoff_trip         <= state_next != ST_RUN;
      fault_latched       <= state_next == ST_LOCKED;
      safe_state_output_a <= status_on;
      safe_state_output_b <= status_on;
    end
  end

  // Checks
  property p_lock_stays;
    @(posedge clk) disable iff (!resetn) fault_latched |=> fault_latched;
  endproperty
  a_lock_stays: assert property (p_lock_stays) else $error("fault cleared");

  property p_lock_no_run;
    @(posedge clk) disable iff (!resetn) fault_latched |-> !torque_enable && !start_allowed;
  endproperty
  a_lock_no_run: assert property (p_lock_no_run) else $error("run while locked");

  property p_status_excl;
    @(posedge clk) disable iff (!resetn) safe_state_output_a |-> !torque_enable && cutoff_trip;
  endproperty
  a_status_excl: assert property (p_status_excl) else $error("status on while running");

  property p_unpowered;
    @(posedge clk) disable iff (!resetn)
      !logic_powered |=> !torque_enable && !safe_state_output_a && !start_allowed;
  endproperty
  a_unpowered: assert property (p_unpowered) else $error("active while unpowered");

  property p_disagree_block;
    @(posedge clk) disable iff (!resetn) state_reg == ST_DISAGREE |-> !start_allowed;
  endproperty
  a_disagree_block: assert property (p_disagree_block) else $error("start in discrepancy");

  property p_short_disc;
    @(posedge clk) disable iff (!resetn)
      $rose(disagree) && !fault_latched |-> !fault_latched [*8];
  endproperty
  a_short_disc: assert property (p_short_disc) else $error("early fault");

  property p_run_both;
    @(posedge clk) disable iff (!resetn) start_allowed |-> $past(both_high);
  endproperty
  a_run_both: assert property (p_run_both) else $error("start without both permits");

  property p_pulse_immune;
    @(posedge clk) disable iff (!resetn) $fell(sync2_reg[0]) |=> filt_reg[0];
  endproperty
  a_pulse_immune: assert property (p_pulse_immune) else $error("pulse not filtered");

  property p_sync_path;
    @(posedge clk) disable iff (!resetn) $past(sync1_reg) != sync2_reg |-> 1'b0;
  endproperty
  a_sync_path: assert property (p_sync_path) else $error("synchroniser broken");

  c_run:    cover property (@(posedge clk) disable iff (!resetn) $rose(torque_enable));
  c_safe:   cover property (@(posedge clk) disable iff (!resetn) $rose(safe_state_output_a));
  c_lock:   cover property (@(posedge clk) disable iff (!resetn) $rose(fault_latched));
  c_recov:  cover property (@(posedge clk) disable iff (!resetn)
                            state_reg == ST_DISAGREE ##1 state_reg == ST_RUN);
endmodule : safe_torque_cutoff

// *** permit_source.sv ***
// Model of the external safety relays that drive both permit channels
`timescale 1ns/1ps
module permit_source
  import torque_cutoff_pkg::*;
(
  // Clock
  input  wire logic       clk,
  // Wanted channel levels
  input  wire logic       want_a,
  input  wire logic       want_b,
  // Channels to the drive
  output permit_pair_type permit
);
  // Both contacts move on one edge, so the model opens no discrepancy window.
  // The bench holds reset across the first edges, so the unknown start is never seen.
  always @(posedge clk) begin
    permit <= '{chan_a: want_a, chan_b: want_b};
  end
endmodule : permit_source

// *** safe_torque_cutoff_test.sv ***
// Self-checking bench for the dual-channel torque cutoff monitor
`timescale 1ns/1ps
module safe_torque_cutoff_test;
  import torque_cutoff_pkg::*;
  logic            clk, resetn, logic_powered, mains_powered, software_run;
  logic            want_a, want_b;     // Levels asked of the relay model
  permit_pair_type permit_in;          // Channels seen by the drive
  wire logic [5:0] outs;               // Torque, start, trip, fault, status a, status b
  int              miscompares, checks;

  // Short counts keep the run brief; expectations use the same values
  safe_torque_cutoff #(.FILTER_LEN(4), .DISC_LEN(50)) i_dut (
    .clk(clk), .resetn(resetn), .logic_powered(logic_powered),
    .mains_powered(mains_powered), .permit_in(permit_in), .software_run(software_run),
    .torque_enable(outs[5]), .start_allowed(outs[4]), .cutoff_trip(outs[3]),
    .fault_latched(outs[2]), .safe_state_output_a(outs[1]), .safe_state_output_b(outs[0]));

  permit_source i_relays (.clk(clk), .want_a(want_a), .want_b(want_b), .permit(permit_in));

  // Set {chan a, chan b, logic supply, mains supply} on an edge, then settle
  task automatic drive(logic [3:0] v, int n);
    @(posedge clk);
    {want_a, want_b, logic_powered, mains_powered} <= v;
    repeat (n) @(posedge clk);
    #1;
  endtask : drive

  // Compare the whole output group at once
  task automatic compare(string what, logic [5:0] exp);
    checks++;
    if (outs !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %b seen %b", what, exp, outs);
    end
  endtask : compare

  // Verdict and end of run
  task automatic end_sim;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim

  // Free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Watchdog, far beyond the fewer than 200 cycles the tests need
  initial begin
    repeat (3000) @(posedge clk);
    miscompares++;
    end_sim();
  end

  // Main sequence
  initial begin
    resetn = 1'b0;
    {want_a, want_b, logic_powered, mains_powered} = 4'h3;
    software_run = 1'b1;
    miscompares = 0;
    checks = 0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    drive(4'h3, 8); compare("both low", 6'h0B);
    drive(4'hF, 8); compare("both high", 6'h30);
    $display("test states done");
    // A test pulse shorter than the filter must leave the drive running
    drive(4'h7, 2); compare("short pulse", 6'h30);
    drive(4'hF, 8); compare("after pulse", 6'h30);
    // Software alone withdraws torque while start stays allowed
    @(posedge clk);
    software_run <= 1'b0;
    drive(4'hF, 2); compare("software stop", 6'h10);
    @(posedge clk);
    software_run <= 1'b1;
    drive(4'hF, 2); compare("software run", 6'h30);
    $display("test pulse done");
    // Torque is still on before the filter expires, off once it has
    drive(4'h7, 3); compare("early drop", 6'h30);
    drive(4'h7, 27); compare("one low", 6'h08);
    drive(4'hF, 8); compare("recovered", 6'h30);
    // One unbroken gap runs past the limit and latches; restoring both channels leaves it locked
    drive(4'h7, 40); compare("second gap", 6'h08);
    drive(4'h7, 30); compare("long gap", 6'h0C);
    drive(4'hF, 10); compare("stays locked", 6'h0C);
    $display("test discrepancy done");
    // Only a power cycle clears the lock
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    drive(4'h1, 8); compare("unpowered", 6'h08);
    drive(4'h2, 8); compare("aux only", 6'h0B);
    drive(4'hE, 8); compare("aux only high", 6'h00);
    $display("test power done");
    end_sim();
  end
endmodule : safe_torque_cutoff_test
